// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	logic		mclk = 0, rst_n = 0, discharge_start = 0, source_req = 0;
	logic		bus_in_range = 0, bus_above_uvlo = 1;
	logic		supply_above_undervolt_level = 1, supply_below_overvolt_level = 1;
	logic		reg_wr, bus_valid_cond, discharge_active_flag, source_enable_out;
	logic [7:0]	reg_addr, reg_wdata, reg_rdata;
	logic [1:0]	safe_zero_level_sel;
	int		fail_count = 0, compares = 0, hi_cnt = 0;

	vdm_regs #(.UNIT_CYC(10)) DUT (.*);
	vdm_host_model host (.*);

	initial forever #10 mclk = ~mclk;
	always @(negedge mclk) hi_cnt += discharge_active_flag;

	task automatic chk(logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t %h %h", $time, s, e);
		end
	endtask

	task automatic rc(logic [7:0] a, e);
		logic [7:0] v;
		host.rd(a, v);
		chk(v, e);
	endtask

	task automatic finish_test;
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic t_defaults;
		rc(8'h25, 8'h6F);
		rc(8'h26, 8'h00);
		rc(8'h27, 8'h00);
		rc(8'h2E, 8'h01);
		rc(8'h30, 8'h00);
	endtask

	task automatic t_monitor;
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h2E, 8'hA8 | 8'(i << 1));
			rc(8'h2E, 8'(i << 1));
			chk(8'(safe_zero_level_sel), 8'(i));
		end
		host.wr(8'h2E, 8'h51);
		rc(8'h2E, 8'h51);
		chk(8'(bus_valid_cond), 8'h01);
		host.wr(8'h2E, 8'h00);
		rc(8'h2E, 8'h00);
		chk(8'(bus_valid_cond), 8'h00);
	endtask

	task automatic t_source;
		@(posedge mclk) source_req <= 1;
		bus_in_range <= 1;
		supply_above_undervolt_level <= 0;
		rc(8'h27, 8'h00);
		@(posedge mclk) supply_above_undervolt_level <= 1;
		supply_below_overvolt_level <= 0;
		rc(8'h27, 8'h00);
		@(posedge mclk) supply_below_overvolt_level <= 1;
		rc(8'h27, 8'h01);
		@(posedge mclk) bus_in_range <= 0;
		rc(8'h27, 8'h00);
		@(posedge mclk) bus_in_range <= 1;
		supply_below_overvolt_level <= 0;
		host.wr(8'h2E, 8'h41);
		rc(8'h27, 8'h01);
	endtask

	task automatic t_discharge;
		host.wr(8'h25, 8'h20);
		rc(8'h25, 8'h2F);
		@(posedge mclk) discharge_start <= 1;
		@(posedge mclk) discharge_start <= 0;
		rc(8'h26, 8'h80);
		chk(8'(source_enable_out), 8'h00);
		repeat (30) @(negedge mclk);
		chk(8'(hi_cnt), 8'h14);
		rc(8'h27, 8'h01);
		host.wr(8'h26, 8'hFF);
		rc(8'h26, 8'h00);
	endtask

	task automatic t_reset;
		host.wr(8'h25, 8'h90);
		rc(8'h25, 8'h9F);
		host.wr(8'h2E, 8'h56);
		rc(8'h2E, 8'h56);
		@(posedge mclk) rst_n <= 0;
		repeat (2) @(posedge mclk);
		rst_n <= 1;
		repeat (2) @(posedge mclk);
		rc(8'h2E, 8'h01);
		rc(8'h25, 8'h6F);
		chk(8'(source_enable_out), 8'h00);
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1;
		repeat (2) @(posedge mclk);
		t_defaults;
		t_monitor;
		t_source;
		t_discharge;
		t_reset;
		finish_test;
	end

	initial begin
		#100000;
		fail_count++;
		finish_test;
	end
endmodule

// ---- bench/vdm_host_model.sv ----
`timescale 1ns/100ps
module vdm_host_model (
	input wire logic	mclk,
	output logic [7:0]	reg_addr = 8'h00,
	output logic		reg_wr = 1'b0,
	output logic [7:0]	reg_wdata = 8'h00,
	input wire logic [7:0]	reg_rdata
);
	task automatic wr(logic [7:0] a, v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// Stale data never looks valid
		reg_wdata <= ~v;
	endtask

	task automatic rd(logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		@(posedge mclk);
		@(negedge mclk);
		v = reg_rdata;
	endtask
endmodule

// ---- bench/vdm_regs_assertions.sv ----
`timescale 1ns/100ps
module vdm_regs_assertions (
	input wire logic	mclk,
	input wire logic	rst_n,
	input wire logic [7:0]	reg_addr,
	input wire logic	reg_wr,
	input wire logic [7:0]	reg_wdata,
	input wire logic [7:0]	reg_rdata,
	input wire logic	bus_in_range,
	input wire logic	bus_above_uvlo,
	input wire logic	supply_above_undervolt_level,
	input wire logic	supply_below_overvolt_level,
	input wire logic	bus_valid_cond,
	input wire logic [1:0]	safe_zero_level_sel,
	input wire logic	discharge_active_flag,
	input wire logic	source_enable_out
);
	logic [7:0]	mon_q;

	// ----
	// Shadow config, reserved bits dropped
	// ----
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			mon_q <= 8'h01;
		else if (reg_wr && reg_addr == 8'h2E)
			mon_q <= reg_wdata & 8'h57;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_bus_select: assert property (1'b1 |=> bus_valid_cond ==
		($past(mon_q[4]) ? $past(bus_above_uvlo) : $past(bus_in_range)))
		else $error("bus select");
	a_safe_zero: assert property (safe_zero_level_sel == mon_q[2:1])
		else $error("safe zero");
	a_ovlo_gate: assert property (!mon_q[6] && !supply_below_overvolt_level
		|=> !source_enable_out) else $error("ovlo gate");
	a_uvlo_gate: assert property (!mon_q[0] && !supply_above_undervolt_level
		|=> !source_enable_out) else $error("uvlo gate");
	a_src_read: assert property (reg_addr == 8'h27
		|=> reg_rdata == {7'h0, $past(source_enable_out)}) else $error("src read");
	a_dis_read: assert property (reg_addr == 8'h26
		|=> reg_rdata == {$past(discharge_active_flag), 7'h0}) else $error("dis read");
	a_src_off_dis: assert property (discharge_active_flag [*2] |-> !source_enable_out)
		else $error("src in discharge");
	a_mon_read: assert property (reg_addr == 8'h2E && !reg_wr
		|=> reg_rdata == $past(mon_q)) else $error("mon read");

	c_discharge: cover property ($fell(discharge_active_flag));
	c_src_on: cover property (source_enable_out);
	c_uvlo_on: cover property (!mon_q[0]);
endmodule

bind vdm_regs vdm_regs_assertions u_chk (.*);

// ---- design/vdm_defines.svh ----
`ifndef VDM_DEFINES_SVH
`define VDM_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VDM_OFS_DIS_TIME   8'h25
`define VDM_OFS_DIS_STATE  8'h26
`define VDM_OFS_SRC_STATE  8'h27
`define VDM_OFS_MON_CFG    8'h2E

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VDM_COEF_HI        7
`define VDM_COEF_LO        4
`define VDM_DIS_ACT_BIT    7
`define VDM_SRC_ON_BIT     0
`define VDM_OVLO_OFF_BIT   6
`define VDM_RANGE_OFF_BIT  4
`define VDM_SAFE0_HI       2
`define VDM_SAFE0_LO       1
`define VDM_UVLO_OFF_BIT   0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VDM_RST_COEF       4'h6
`define VDM_RST_TIME_LOW   4'hF
`define VDM_RST_OVLO_OFF   1'b0
`define VDM_RST_RANGE_OFF  1'b0
`define VDM_RST_SAFE0      2'h0
`define VDM_RST_UVLO_OFF   1'b1

// ----------------------------------------
// Timing
// ----------------------------------------
`define VDM_UNIT_MS        84
`define VDM_CLK_KHZ        50000
`define VDM_UNIT_CYC       (`VDM_UNIT_MS * `VDM_CLK_KHZ)

`endif

// ---- design/vdm_pkg.sv ----
package vdm_pkg;

	typedef enum logic [1:0] {
		VDM_SAFE0_0V6 = 2'h0,
		VDM_SAFE0_0V9 = 2'h1,
		VDM_SAFE0_1V2 = 2'h2,
		VDM_SAFE0_1V8 = 2'h3
	} vdm_safe0_t;

	typedef enum logic [1:0] {
		VDM_DIS_IDLE = 2'h1,
		VDM_DIS_RUN  = 2'h2
	} vdm_dis_state_t;

endpackage

// ---- design/vdm_regs.sv ----
`timescale 1ns/100ps
`include "vdm_defines.svh"

// Notes on behaviour
// - Discharge time is coefficient times 84 ms
// - Status bit 7 shows discharge path active
// - Enable status bit 0 shows source path
// - Monitor bit 6 one disables supply overvoltage
// - Monitor bit 4 one uses undervoltage check
// - Selected bus check gates attach and path
// - Monitor bits 2:1 select safe-zero level
// - Safe-zero level feeds attach conditions
// - Monitor bit 0 one disables supply undervoltage
// - Undervoltage enabled: enable only above level
// - Overvoltage enabled: enable only below level
// - Reset loads defaults; writes override them
module vdm_regs #(
	parameter int         UNIT_CYC      = `VDM_UNIT_CYC,
	parameter logic [3:0] NVM_COEF      = `VDM_RST_COEF,
	parameter logic       NVM_OVLO_OFF  = `VDM_RST_OVLO_OFF,
	parameter logic       NVM_RANGE_OFF = `VDM_RST_RANGE_OFF,
	parameter logic [1:0] NVM_SAFE0     = `VDM_RST_SAFE0,
	parameter logic       NVM_UVLO_OFF  = `VDM_RST_UVLO_OFF
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       discharge_start,
	input  wire logic       source_req,
	input  wire logic       bus_in_range,
	input  wire logic       bus_above_uvlo,
	input  wire logic       supply_above_undervolt_level,
	input  wire logic       supply_below_overvolt_level,
	output logic            bus_valid_cond,
	output logic      [1:0] safe_zero_level_sel,
	output logic            discharge_active_flag,
	output logic            source_enable_out
);

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	logic wr_time;
	logic wr_mon;

	// Status and unmapped addresses decode to nothing, so writes there fall away
	assign wr_time = reg_wr && (reg_addr == `VDM_OFS_DIS_TIME);
	assign wr_mon  = reg_wr && (reg_addr == `VDM_OFS_MON_CFG);

	// ----------------------------------------
	// Default load
	// ----------------------------------------
	logic nvm_load_q;

	// Async reset takes constants only; the strap values land one edge later
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_load_q <= 1'b1;
		end else begin
			nvm_load_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [3:0] coef_q;
	logic       ovlo_off_q;
	logic       range_off_q;
	logic [1:0] safe0_q;
	logic       uvlo_off_q;

	// Parameters stand in for the non-volatile defaults
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			coef_q <= `VDM_RST_COEF;
		end else if (nvm_load_q) begin
			coef_q <= NVM_COEF;
		end else if (wr_time) begin
			coef_q <= reg_wdata[`VDM_COEF_HI:`VDM_COEF_LO];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ovlo_off_q  <= `VDM_RST_OVLO_OFF;
			range_off_q <= `VDM_RST_RANGE_OFF;
			safe0_q     <= `VDM_RST_SAFE0;
			uvlo_off_q  <= `VDM_RST_UVLO_OFF;
		end else if (nvm_load_q) begin
			ovlo_off_q  <= NVM_OVLO_OFF;
			range_off_q <= NVM_RANGE_OFF;
			safe0_q     <= NVM_SAFE0;
			uvlo_off_q  <= NVM_UVLO_OFF;
		end else if (wr_mon) begin
			ovlo_off_q  <= reg_wdata[`VDM_OVLO_OFF_BIT];
			range_off_q <= reg_wdata[`VDM_RANGE_OFF_BIT];
			safe0_q     <= reg_wdata[`VDM_SAFE0_HI:`VDM_SAFE0_LO];
			uvlo_off_q  <= reg_wdata[`VDM_UVLO_OFF_BIT];
		end
	end

	// ----------------------------------------
	// Discharge timer
	// ----------------------------------------
	vdm_pkg::vdm_dis_state_t dis_state_q;
	logic [3:0]              units_q;
	logic                    unit_tick;

	vdm_unit_tick #(
		.UNIT_CYC (UNIT_CYC)
	) u_tick (
		.mclk  (mclk),
		.rst_n (rst_n),
		.run   (dis_state_q == vdm_pkg::VDM_DIS_RUN),
		.tick  (unit_tick)
	);

	// Coefficient latched at start; a later write does not stretch a running discharge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dis_state_q <= vdm_pkg::VDM_DIS_IDLE;
			units_q     <= 4'h0;
		end else begin
			case (dis_state_q)
				vdm_pkg::VDM_DIS_IDLE: begin
					if (discharge_start && coef_q != 4'h0) begin
						dis_state_q <= vdm_pkg::VDM_DIS_RUN;
						units_q     <= coef_q;
					end
				end
				vdm_pkg::VDM_DIS_RUN: begin
					if (unit_tick) begin
						units_q <= units_q - 4'h1;
						if (units_q == 4'h1) begin
							dis_state_q <= vdm_pkg::VDM_DIS_IDLE;
						end
					end
				end
				default: begin
					dis_state_q <= vdm_pkg::VDM_DIS_IDLE;
				end
			endcase
		end
	end

	assign discharge_active_flag = (dis_state_q == vdm_pkg::VDM_DIS_RUN);

	// ----------------------------------------
	// Monitoring and source path
	// ----------------------------------------
	logic bus_sel;
	logic bus_valid_q;

	// Source path uses the live select; the attach side gets a registered copy
	assign bus_sel             = range_off_q ? bus_above_uvlo : bus_in_range;
	assign safe_zero_level_sel = safe0_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_valid_q <= 1'b0;
		end else begin
			bus_valid_q <= bus_sel;
		end
	end

	assign bus_valid_cond = bus_valid_q;

	logic src_d;
	logic src_q;

	always_comb begin
		src_d = source_req && bus_sel;
		if (!uvlo_off_q && !supply_above_undervolt_level) begin
			src_d = 1'b0;
		end
		if (!ovlo_off_q && !supply_below_overvolt_level) begin
			src_d = 1'b0;
		end
		if (discharge_active_flag) begin
			src_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= 1'b0;
		end else begin
			src_q <= src_d;
		end
	end

	assign source_enable_out = src_q;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [7:0] rd_d;

	always_comb begin
		rd_d = 8'h00;
		if (reg_addr == `VDM_OFS_DIS_TIME) begin
			rd_d = {coef_q, `VDM_RST_TIME_LOW};
		end else if (reg_addr == `VDM_OFS_DIS_STATE) begin
			rd_d[`VDM_DIS_ACT_BIT] = discharge_active_flag;
		end else if (reg_addr == `VDM_OFS_SRC_STATE) begin
			rd_d[`VDM_SRC_ON_BIT] = src_q;
		end else if (reg_addr == `VDM_OFS_MON_CFG) begin
			rd_d[`VDM_OVLO_OFF_BIT]            = ovlo_off_q;
			rd_d[`VDM_RANGE_OFF_BIT]           = range_off_q;
			rd_d[`VDM_SAFE0_HI:`VDM_SAFE0_LO]  = safe0_q;
			rd_d[`VDM_UVLO_OFF_BIT]            = uvlo_off_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rd_d;
		end
	end

endmodule

// ---- design/vdm_unit_tick.sv ----
`timescale 1ns/100ps
`include "vdm_defines.svh"

// ----------------------------------------
// Discharge time unit tick divider
// ----------------------------------------
module vdm_unit_tick #(
	parameter int UNIT_CYC = `VDM_UNIT_CYC
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      tick
);

	logic [31:0] cnt_q;

	// Restarts whenever idle so each unit is full length
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
		end else if (!run || tick) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	assign tick = run && (cnt_q == 32'(UNIT_CYC - 1));

endmodule
